// ---- core/dcs_core.sv ----
// Four-channel DAC code holding, linear slew, fallback and input threshold
`timescale 1ns/1ps
`include "dcs_defs.svh"

module dcs_core #(
  parameter int RATE0_CYCLES = `DCS_CLK_HZ / `DCS_RATE0_HZ
) (
  input  wire logic                         clk_in,
  input  wire logic                         rst_in,
  input  wire dcs_pkg::dcs_reg_req_s        reg_req_in,
  input  wire dcs_pkg::dcs_chan_cfg_s [3:0] chan_cfg_in,
  input  wire logic                         fallback_key_in,
  input  wire logic                         load_converter_n_in,
  output logic                   [15:0]     rdata_out,
  output logic                   [3:0][12:0] dac_code_out,
  output logic                   [3:0]      current_limit_low_out,
  output logic                   [4:0]      comparator_level_out,
  output logic                              threshold_reference_select_out
);
  import dcs_pkg::*;

  localparam int RATE1_CYCLES = `DCS_CLK_HZ / `DCS_RATE1_HZ;
  localparam int RATE2_CYCLES = `DCS_CLK_HZ / `DCS_RATE2_HZ;
  localparam int RATE3_CYCLES = `DCS_CLK_HZ / `DCS_RATE3_HZ;

  dcs_state_s s_reg;
  dcs_state_s s_next;
  logic [3:0] tick;

  function automatic logic [13:0] step_of(input logic [1:0] sel);
    case (sel)
      2'h0:    step_of = `DCS_STEP0;
      2'h1:    step_of = `DCS_STEP1;
      2'h2:    step_of = `DCS_STEP2;
      default: step_of = `DCS_STEP3;
    endcase
  endfunction

  // Last count of the update divider; a rate is a period rounded down
  function automatic logic [12:0] last_of(input logic [1:0] sel);
    case (sel)
      2'h0:    last_of = 13'(RATE0_CYCLES - 1);
      2'h1:    last_of = 13'(RATE1_CYCLES - 1);
      2'h2:    last_of = 13'(RATE2_CYCLES - 1);
      default: last_of = 13'(RATE3_CYCLES - 1);
    endcase
  endfunction

  function automatic logic [12:0] walk(input logic [12:0] cur,
                                       input logic [12:0] goal,
                                       input logic [13:0] step);
    logic [13:0] diff;
    diff = 14'h0000;
    walk = cur;
    if (cur < goal) begin
      diff = {1'b0, goal} - {1'b0, cur};
      if (diff <= step) begin
        walk = goal;
      end else begin
        walk = 13'({1'b0, cur} + step);
      end
    end else if (cur > goal) begin
      diff = {1'b0, cur} - {1'b0, goal};
      if (diff <= step) begin
        walk = goal;
      end else begin
        walk = 13'({1'b0, cur} - step);
      end
    end
  endfunction

  always_comb begin
    s_next = s_reg;
    tick   = 4'h0;
    s_next.rdata = 16'h0000;

    // Register writes; reserved bits are simply not stored
    if (reg_req_in.wr) begin
      if (reg_req_in.addr >= `DCS_ADDR_TARGET0 &&
          reg_req_in.addr <= `DCS_ADDR_TARGET3) begin
        s_next.target[2'(reg_req_in.addr - `DCS_ADDR_TARGET0)] =
          reg_req_in.wdata[`DCS_CODE_MSB:0];
      end else if (reg_req_in.addr >= `DCS_ADDR_FALLBACK0 &&
                   reg_req_in.addr <= `DCS_ADDR_FALLBACK3) begin
        s_next.fallback[2'(reg_req_in.addr - `DCS_ADDR_FALLBACK0)] =
          reg_req_in.wdata[`DCS_CODE_MSB:0];
      end else if (reg_req_in.addr == `DCS_ADDR_THRESH) begin
        s_next.thresh = reg_req_in.wdata[`DCS_LEVEL_MSB:0];
      end
    end

    // Reads answer one cycle later; unmapped addresses read zero
    if (reg_req_in.rd) begin
      if (reg_req_in.addr >= `DCS_ADDR_TARGET0 &&
          reg_req_in.addr <= `DCS_ADDR_TARGET3) begin
        s_next.rdata = {3'h0,
          s_reg.target[2'(reg_req_in.addr - `DCS_ADDR_TARGET0)]};
      end else if (reg_req_in.addr >= `DCS_ADDR_FALLBACK0 &&
                   reg_req_in.addr <= `DCS_ADDR_FALLBACK3) begin
        s_next.rdata = {3'h0,
          s_reg.fallback[2'(reg_req_in.addr - `DCS_ADDR_FALLBACK0)]};
      end else if (reg_req_in.addr >= `DCS_ADDR_APPLIED0 &&
                   reg_req_in.addr <= `DCS_ADDR_APPLIED3) begin
        s_next.rdata = {3'h0,
          s_reg.applied[2'(reg_req_in.addr - `DCS_ADDR_APPLIED0)]};
      end else if (reg_req_in.addr == `DCS_ADDR_THRESH) begin
        s_next.rdata = {10'h000, s_reg.thresh};
      end
    end

    for (int i = 0; i < 4; i++) begin
      s_next.ilim[i] = chan_cfg_in[i].current_limit_sel;
      // Goal follows the target only while the load strobe is low
      if (!load_converter_n_in) begin
        s_next.goal[i] = s_reg.target[i];
      end
      if (chan_cfg_in[i].slew_mode == `DCS_SLEW_ON) begin
        if (s_reg.div_cnt[i] >= last_of(chan_cfg_in[i].slew_rate)) begin
          tick[i] = 1'b1;
          s_next.div_cnt[i] = 13'h0000;
          s_next.applied[i] = walk(s_reg.applied[i], s_reg.goal[i],
                                   step_of(chan_cfg_in[i].slew_step));
        end else begin
          s_next.div_cnt[i] = s_reg.div_cnt[i] + 13'h0001;
        end
      end else begin
        s_next.div_cnt[i] = 13'h0000;
        s_next.applied[i] = s_next.goal[i];
      end
      // Fallback bypasses slewing so a clear lands at once
      if (fallback_key_in && chan_cfg_in[i].fallback_enable) begin
        s_next.goal[i]    = s_reg.fallback[i];
        s_next.applied[i] = s_reg.fallback[i];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_reg.target   <= {4{`DCS_CODE_RESET}};
      s_reg.fallback <= {4{`DCS_CODE_RESET}};
      s_reg.goal     <= {4{`DCS_CODE_RESET}};
      s_reg.applied  <= {4{`DCS_CODE_RESET}};
      s_reg.div_cnt  <= {4{13'h0000}};
      s_reg.ilim     <= 4'h0;
      s_reg.thresh   <= `DCS_THRESH_RESET;
      s_reg.rdata    <= 16'h0000;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata_out                      = s_reg.rdata;
  assign dac_code_out                   = s_reg.applied;
  assign current_limit_low_out          = s_reg.ilim;
  assign comparator_level_out           =
    s_reg.thresh[`DCS_LEVEL_MSB:`DCS_LEVEL_LSB];
  assign threshold_reference_select_out = s_reg.thresh[`DCS_REFSEL_BIT];

  // Checks on channel 0 stand for all four; the loop body is shared
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  logic slew0;
  logic key0;
  assign slew0 = chan_cfg_in[0].slew_mode == `DCS_SLEW_ON;
  assign key0  = fallback_key_in && chan_cfg_in[0].fallback_enable;

  sequence load_pulse;
    !load_converter_n_in && !key0 && !slew0;
  endsequence

  // Eight cycles of unchanged slowest-rate slewing after an update
  sequence slow_run;
    (slew0 && chan_cfg_in[0].slew_rate == 2'h0) [*8];
  endsequence

  chk_jump_no_slew: assert property (
    load_pulse |=> dac_code_out[0] == $past(s_reg.target[0]))
    else $error("applied code did not jump to target on load");

  chk_hold_no_load: assert property (
    load_converter_n_in && !key0 && !tick[0] && !$changed(s_reg.goal[0])
    |=> $stable(dac_code_out[0]))
    else $error("applied code moved without a load or update");

  chk_step_size: assert property (
    tick[0] && s_reg.goal[0] > s_reg.applied[0] && !key0 &&
    ({1'b0, s_reg.goal[0]} - {1'b0, s_reg.applied[0]}) >
      step_of(chan_cfg_in[0].slew_step)
    |=> {1'b0, dac_code_out[0]} ==
        {1'b0, $past(s_reg.applied[0])} +
        $past(step_of(chan_cfg_in[0].slew_step)))
    else $error("slew step size wrong");

  // Downward walks use the same step
  chk_step_down: assert property (
    tick[0] && s_reg.goal[0] < s_reg.applied[0] && !key0 &&
    ({1'b0, s_reg.applied[0]} - {1'b0, s_reg.goal[0]}) >
      step_of(chan_cfg_in[0].slew_step)
    |=> {1'b0, dac_code_out[0]} ==
        {1'b0, $past(s_reg.applied[0])} -
        $past(step_of(chan_cfg_in[0].slew_step)))
    else $error("slew step down size wrong");

  chk_land_down: assert property (
    tick[0] && !key0 && s_reg.goal[0] < s_reg.applied[0] &&
    ({1'b0, s_reg.applied[0]} - {1'b0, s_reg.goal[0]}) <=
      step_of(chan_cfg_in[0].slew_step)
    |=> dac_code_out[0] == $past(s_reg.goal[0]))
    else $error("downward slew did not land on goal");

  chk_land_exact: assert property (
    tick[0] && !key0 && s_reg.goal[0] >= s_reg.applied[0] &&
    ({1'b0, s_reg.goal[0]} - {1'b0, s_reg.applied[0]}) <=
      step_of(chan_cfg_in[0].slew_step)
    |=> dac_code_out[0] == $past(s_reg.goal[0]))
    else $error("slew did not land on goal");

  chk_rate_fast: assert property (
    slew0 && chan_cfg_in[0].slew_rate == 2'h3 && tick[0] ##1
    (slew0 && chan_cfg_in[0].slew_rate == 2'h3) [*8]
    |-> !tick[0])
    else $error("slew update came too early");

  chk_rate_gap: assert property (
    slew0 && chan_cfg_in[0].slew_rate == 2'h0 && tick[0] ##1 slow_run
    |-> !tick[0])
    else $error("slow slew update came too early");

  // A rate change may leave one cycle above the new last count
  chk_rate_bound: assert property (
    slew0 && $past(slew0) && $stable(chan_cfg_in[0].slew_rate)
    |-> s_reg.div_cnt[0] <= last_of(chan_cfg_in[0].slew_rate))
    else $error("update divider overran");

  chk_div_count: assert property (
    slew0 && !tick[0]
    |=> s_reg.div_cnt[0] == $past(s_reg.div_cnt[0]) + 13'h0001)
    else $error("update divider did not count");

  chk_div_wrap: assert property (
    tick[0] |=> s_reg.div_cnt[0] == 13'h0000)
    else $error("update divider did not restart");

  // Divider parked while slewing is off
  chk_slew_off_div: assert property (
    !slew0 |=> s_reg.div_cnt[0] == 13'h0000)
    else $error("update divider ran with slewing off");

  chk_goal_held: assert property (
    load_converter_n_in && !key0
    |=> $stable(s_reg.goal[0]))
    else $error("goal moved while load strobe high");

  chk_target_write: assert property (
    reg_req_in.wr && reg_req_in.addr == `DCS_ADDR_TARGET0
    |=> s_reg.target[0] == $past(reg_req_in.wdata[12:0]))
    else $error("target code write not stored");

  chk_fallback_write: assert property (
    reg_req_in.wr && reg_req_in.addr == `DCS_ADDR_FALLBACK0
    |=> s_reg.fallback[0] == $past(reg_req_in.wdata[12:0]))
    else $error("fallback code write not stored");

  chk_fallback_load: assert property (
    key0 |=> dac_code_out[0] == $past(s_reg.fallback[0]))
    else $error("fallback code not loaded");

  // Goal follows so a running walk does not undo the clear
  chk_fallback_goal: assert property (
    key0 |=> s_reg.goal[0] == $past(s_reg.fallback[0]))
    else $error("fallback code not taken as goal");

  chk_fallback_off: assert property (
    fallback_key_in && !chan_cfg_in[0].fallback_enable && slew0 &&
    !tick[0] |=> $stable(dac_code_out[0]))
    else $error("fallback key acted on a disabled channel");

  chk_readback_applied: assert property (
    reg_req_in.rd && reg_req_in.addr == `DCS_ADDR_APPLIED0
    |=> rdata_out == {3'h0, $past(s_reg.applied[0])})
    else $error("applied code readback wrong");

  chk_readback_target: assert property (
    reg_req_in.rd && reg_req_in.addr == `DCS_ADDR_TARGET0
    |=> rdata_out == {3'h0, $past(s_reg.target[0])})
    else $error("target code readback wrong");

  chk_readback_thresh: assert property (
    reg_req_in.rd && reg_req_in.addr == `DCS_ADDR_THRESH
    |=> rdata_out == {10'h000, $past(s_reg.thresh)})
    else $error("threshold readback wrong");

  // Addresses past the block answer zero
  chk_unmapped_zero: assert property (
    reg_req_in.rd && reg_req_in.addr > `DCS_ADDR_THRESH
    |=> rdata_out == 16'h0000)
    else $error("unmapped address read nonzero");

  // Read data stands for one cycle only
  chk_rdata_idle: assert property (
    !reg_req_in.rd |=> rdata_out == 16'h0000)
    else $error("read data stood without a read");

  chk_reserved_zero: assert property (
    rdata_out[15:13] == 3'h0)
    else $error("reserved bits read nonzero");

  chk_thresh_fields: assert property (
    reg_req_in.wr && reg_req_in.addr == `DCS_ADDR_THRESH
    |=> comparator_level_out == $past(reg_req_in.wdata[5:1]) &&
        threshold_reference_select_out == $past(reg_req_in.wdata[0]))
    else $error("threshold register fields wrong");

  // Shared level must not drift between writes
  chk_thresh_hold: assert property (
    !(reg_req_in.wr && reg_req_in.addr == `DCS_ADDR_THRESH)
    |=> $stable(comparator_level_out) &&
        $stable(threshold_reference_select_out))
    else $error("threshold fields changed without a write");

  chk_current_limit: assert property (
    ##1 current_limit_low_out[0] == $past(chan_cfg_in[0].current_limit_sel))
    else $error("current limit select not passed on");

endmodule // dcs_core

// ---- include/dcs_defs.svh ----
// Offsets, field positions, reset values and timing figures for the DAC slew block
`ifndef DCS_DEFS_SVH
`define DCS_DEFS_SVH
`define DCS_ADDR_TARGET0   8'h16
`define DCS_ADDR_TARGET3   8'h19
`define DCS_ADDR_FALLBACK0 8'h1A
`define DCS_ADDR_FALLBACK3 8'h1D
`define DCS_ADDR_APPLIED0  8'h1E
`define DCS_ADDR_APPLIED3  8'h21
`define DCS_ADDR_THRESH    8'h22
`define DCS_CODE_MSB       12
`define DCS_LEVEL_MSB      5
`define DCS_LEVEL_LSB      1
`define DCS_REFSEL_BIT     0
`define DCS_CODE_RESET     13'h0000
`define DCS_THRESH_RESET   6'h00
`define DCS_SLEW_ON        2'h1
`define DCS_STEP0          14'h0040
`define DCS_STEP1          14'h0078
`define DCS_STEP2          14'h01F4
`define DCS_STEP3          14'h071C
`define DCS_CLK_HZ         20000000
`define DCS_RATE0_HZ       4000
`define DCS_RATE1_HZ       64000
`define DCS_RATE2_HZ       150000
`define DCS_RATE3_HZ       240000
`endif

// ---- include/dcs_pkg.sv ----
// Types shared by the DAC slew and threshold block
package dcs_pkg;
  typedef logic [12:0] dcs_code_t;

  typedef struct packed {
    logic [1:0] slew_mode;
    logic [1:0] slew_step;
    logic [1:0] slew_rate;
    logic       fallback_enable;
    logic       current_limit_sel;
  } dcs_chan_cfg_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } dcs_reg_req_s;

  typedef struct packed {
    logic [3:0][12:0] target;
    logic [3:0][12:0] fallback;
    logic [3:0][12:0] goal;
    logic [3:0][12:0] applied;
    logic [3:0][12:0] div_cnt;
    logic [3:0]       ilim;
    logic [5:0]       thresh;
    logic [15:0]      rdata;
  } dcs_state_s;
endpackage

// ---- testbench/dcs_core_tb_top.sv ----
// Self-checking bench for the DAC slew and threshold block
`timescale 1ns/1ps
module dcs_core_tb_top;
  import dcs_pkg::*;
  logic                clk_in     = 1'b0;
  logic                rst_in     = 1'b1;
  dcs_reg_req_s        req;
  dcs_chan_cfg_s [3:0] cfg        = '0;
  logic                key        = 1'b0;
  logic                load_n     = 1'b1;
  logic [15:0]         rdata;
  logic [3:0][12:0]    dac;
  logic [3:0]          ilim;
  logic [4:0]          level;
  logic                refsel;
  int                  mismatches = 0;
  int                  n_tests    = 0;

  always #25 clk_in = ~clk_in;

  // Short divider keeps the slew walk to six updates of 20 cycles each
  dcs_core #(.RATE0_CYCLES(20)) i_dut (
    .clk_in                         (clk_in),
    .rst_in                         (rst_in),
    .reg_req_in                     (req),
    .chan_cfg_in                    (cfg),
    .fallback_key_in                (key),
    .load_converter_n_in            (load_n),
    .rdata_out                      (rdata),
    .dac_code_out                   (dac),
    .current_limit_low_out          (ilim),
    .comparator_level_out           (level),
    .threshold_reference_select_out (refsel)
  );

  dcs_host_model i_host (
    .clk_in   (clk_in),
    .rdata_in (rdata),
    .req_out  (req)
  );

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic logic [15:0] exp_rd(input logic [7:0] a);
    if (a <= 8'h1D) return 16'h1FFF;
    if (a == 8'h22) return 16'h003F;
    return 16'h0000;
  endfunction

  // Reset values, reserved bits, read-only applied codes, unmapped 0x23
  task automatic reg_map_test;
    logic [15:0] d;
    for (int a = 8'h16; a <= 8'h23; a++) begin
      i_host.read(8'(a), d);
      check("reset read", 16'h0000, d);
    end
    for (int a = 8'h16; a <= 8'h23; a++) i_host.write(8'(a), 16'hFFFF);
    for (int a = 8'h16; a <= 8'h23; a++) begin
      i_host.read(8'(a), d);
      check("reg read", exp_rd(8'(a)), d);
    end
    @(posedge clk_in);
    #1;
    check("level", 16'h001F, {11'h000, level});
    check("refsel", 16'h0001, {15'h0000, refsel});
    check("held code", 16'h0000, 16'(dac[3]));
  endtask

  // Waits a bounded time for channel 0 to move, then checks the code
  task automatic await_code(input logic [15:0] exp,
                            inout logic [12:0] prev, output int t);
    for (t = 0; t < 200 && dac[0] === prev; t++) begin
      @(posedge clk_in);
      #1;
    end
    check("slew step", exp, 16'(dac[0]));
    if (dac[0] === prev) give_verdict();
    prev = dac[0];
  endtask

  // Channel 0 walks 0 to 200 and back to 80; others jump on load
  task automatic slew_test;
    logic [12:0] prev;
    logic [15:0] d;
    int          t;
    @(posedge clk_in);
    cfg[0].slew_mode <= 2'h1;
    i_host.write(8'h16, 16'h00C8);
    @(posedge clk_in);
    load_n <= 1'b0;
    @(posedge clk_in);
    load_n <= 1'b1;
    @(posedge clk_in);
    #1;
    check("jump code", 16'h1FFF, 16'(dac[3]));
    prev = 13'h0000;
    await_code(16'h0040, prev, t);
    await_code(16'h0080, prev, t);
    check("slew period", 16'h0014, 16'(t));
    await_code(16'h00C0, prev, t);
    await_code(16'h00C8, prev, t);
    i_host.read(8'h1E, d);
    check("applied read", 16'h00C8, d);
    i_host.write(8'h16, 16'h0050);
    @(posedge clk_in);
    load_n <= 1'b0;
    @(posedge clk_in);
    load_n <= 1'b1;
    await_code(16'h0088, prev, t);
    await_code(16'h0050, prev, t);
  endtask

  // Key loads only the enabled channel; limit select follows config
  task automatic fallback_test;
    i_host.write(8'h1B, 16'hEABC);
    @(posedge clk_in);
    cfg[1].fallback_enable <= 1'b1;
    cfg[3].current_limit_sel <= 1'b1;
    @(posedge clk_in);
    key <= 1'b1;
    @(posedge clk_in);
    key <= 1'b0;
    @(posedge clk_in);
    #1;
    check("fallback on", 16'h0ABC, 16'(dac[1]));
    check("fallback off", 16'h1FFF, 16'(dac[2]));
    check("current limit", 16'h0008, 16'(ilim));
    check("fallback held", 16'h0050, 16'(dac[0]));
    @(posedge clk_in);
    cfg[0].fallback_enable <= 1'b1;
    @(posedge clk_in);
    key <= 1'b1;
    @(posedge clk_in);
    key <= 1'b0;
    @(posedge clk_in);
    #1;
    check("fallback ch0", 16'h1FFF, 16'(dac[0]));
  endtask

  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    reg_map_test();
    slew_test();
    fallback_test();
    give_verdict();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    give_verdict();
  end
endmodule // dcs_core_tb_top

// ---- testbench/dcs_host_model.sv ----
// Host-side register master for the block's decoded register port
`timescale 1ns/1ps
module dcs_host_model (
  input  wire logic             clk_in,
  input  wire logic [15:0]      rdata_in,
  output dcs_pkg::dcs_reg_req_s req_out
);
  import dcs_pkg::*;
  initial req_out = '0;

  // One-cycle strobe, released only after the taking edge
  task automatic write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    req_out <= '0;
  endtask

  // Read data stands for one cycle after the taking edge
  task automatic read(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_in);
    req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_in);
    req_out <= '0;
    #1 d = rdata_in;
  endtask
endmodule // dcs_host_model
